// *** common/wwc_pkg.sv ***
// Shared constants, types and helpers of the windowed watchdog control block.
package wwc_pkg;

   // Clock and tick rates, in hertz.
   localparam int CLK_HZ = 10_000_000;
   localparam int LF_HZ = 31_000;
   localparam int MF_HZ = 31_250;
   // A tick period is a longest-time figure, so the division rounds down.
   localparam int LF_DIV = CLK_HZ / LF_HZ;
   localparam int MF_DIV = CLK_HZ / MF_HZ;
   localparam int DIV_W = 16;

   // Register byte addresses on the Avalon-MM slave.
   localparam int AW = 5;
   localparam logic [4:0] A_CTRL0 = 5'h00;
   localparam logic [4:0] A_CTRL1 = 5'h04;
   localparam logic [4:0] A_PSL = 5'h08;
   localparam logic [4:0] A_PSH = 5'h0C;
   localparam logic [4:0] A_TMR = 5'h10;
   localparam logic [4:0] A_ISTAT = 5'h14;
   localparam logic [4:0] A_IMASK = 5'h18;
   localparam logic [4:0] A_FLAG = 5'h1C;

   // Field positions.
   localparam int C0_SW_BIT = 0;
   localparam int C0_SCALE_LSB = 1;
   localparam int C1_WIN_LSB = 0;
   localparam int C1_SRC_LSB = 4;
   localparam int TMR_PS_LSB = 0;
   localparam int TMR_STATE_BIT = 2;
   localparam int TMR_CNT_LSB = 3;
   localparam int FLAG_BIT = 0;

   // Counter geometry: 18-bit prescaler below a 5-bit period counter.
   localparam int PS_W = 18;
   localparam int TMR_W = 5;
   localparam int TMR_VIS_W = 4;
   localparam int CNT_W = PS_W + TMR_W;
   localparam logic [4:0] BASE_EXP = 5'h05;
   localparam logic [4:0] WIN_EXP = 5'h02;

   // Field codes and reset values.
   localparam logic [4:0] SCALE_RST = 5'h0B;
   localparam logic [4:0] SCALE_OPEN = 5'h1F;
   localparam logic [4:0] SCALE_MAX = 5'h12;
   localparam logic [4:0] SCALE_MIN = 5'h00;
   localparam logic [2:0] SRC_OPEN = 3'h7;
   localparam logic [2:0] SRC_RST = 3'h0;
   localparam logic [2:0] SRC_MF = 3'h1;
   localparam logic [2:0] WIN_OPEN = 3'h7;
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_SW = 2'h1;
   localparam logic [1:0] MODE_NOSLP = 2'h2;
   localparam logic [1:0] MODE_ON = 2'h3;

   // Event bits of the interrupt status and mask registers.
   localparam int EV_W = 3;
   localparam int EV_TO = 0;
   localparam int EV_WV = 1;
   localparam int EV_WAKE = 2;

   typedef enum logic [1:0] {
      ST_INIT = 2'b00,
      ST_OFF = 2'b01,
      ST_RUN = 2'b11
   } wwc_state_t;

   typedef struct packed {
      logic read;
      logic write;
      logic [AW-1:0] addr;
      logic [3:0] be;
      logic [31:0] wdata;
   } wwc_avs_t;

   typedef struct packed {
      wwc_state_t st;
      logic [4:0] scale;
      logic sw_on;
      logic [2:0] src;
      logic [2:0] win;
      logic [CNT_W-1:0] cnt;
      logic armed;
      logic [EV_W-1:0] ist;
      logic [EV_W-1:0] imask;
      logic wv_n;
      logic slp;
      logic ack;
      logic [31:0] rdata;
      logic rst;
      logic wake;
   } wwc_regs_t;

   typedef struct packed {
      logic [DIV_W-1:0] cnt;
      logic tick;
   } wwc_tick_t;

   // Reserved scale codes fall back to the shortest interval.
   function automatic logic [4:0] wwc_eff(input logic [4:0] sel);
      return (sel > SCALE_MAX) ? SCALE_MIN : sel;
   endfunction

   // Last count of a period of 2^(5+sel) ticks.
   function automatic logic [CNT_W-1:0] wwc_lim(input logic [4:0] sel);
      logic [CNT_W:0] one;
      one = (CNT_W+1)'(1);
      return CNT_W'((one << (wwc_eff(sel) + BASE_EXP)) - one);
   endfunction

   // Closed part of the period: (7 - win) eighths of it.
   function automatic logic [CNT_W-1:0] wwc_delay(input logic [4:0] sel,
                                                  input logic [2:0] win);
      logic [CNT_W-1:0] steps;
      steps = CNT_W'(WIN_OPEN - win);
      return steps << (wwc_eff(sel) + WIN_EXP);
   endfunction

endpackage

// *** core/wwc_tick_gen.sv ***
// Watchdog tick generator: one-cycle tick at the selected low rate.
`timescale 1ns/100ps
module wwc_tick_gen #(
   parameter int LF_DIV = wwc_pkg::LF_DIV,
   parameter int MF_DIV = wwc_pkg::MF_DIV
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_sel_mf,
   output logic o_tick
);
   wwc_pkg::wwc_tick_t q;
   wwc_pkg::wwc_tick_t d;
   logic [wwc_pkg::DIV_W-1:0] last;

   // The slow source is the default; nominal intervals assume it.
   assign last = i_sel_mf ? wwc_pkg::DIV_W'(MF_DIV - 1) : wwc_pkg::DIV_W'(LF_DIV - 1);

   always_comb begin
      d = q;
      d.tick = 1'b0;
      if (q.cnt >= last) begin
         d.cnt = '0;
         d.tick = 1'b1;
      end else begin
         d.cnt = q.cnt + wwc_pkg::DIV_W'(1);
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_tick = q.tick;
endmodule

// *** core/wwc_top.sv ***
// Windowed watchdog control and status logic with an Avalon-MM register slave.
// What this block does
// - Scale select picks prescale 1:32 at code 0, doubling up to 1:8388608.
// - Scale codes 10011 to 11111 behave as the shortest 1:32 interval.
// - Scale resets to 01011 if config scale is 11111, else to config scale.
// - Scale is writable only when config scale is 11111.
// - In software mode the on bit starts or stops the watchdog; else ignored.
// - Tick source 000 is the 31 kHz tick, 001 the 31.25 kHz tick.
// - Tick source resets to 000 if config is 111, else to config, and is writable only when config is 111.
// - Window size 111 is fully open; lower codes close more eighths.
// - Window resets to config window and is writable only if that is 111.
// - The 18-bit prescale count reads back over three registers, reset zero.
// - The low four bits of the 5-bit period count read in timer register bits 6 to 3, reset zero.
// - Timer register bit 2 shows whether the watchdog is armed.
// - Unimplemented bits of the three registers read as zero.
// - Nominal intervals assume the 31 kHz tick and are approximate.
// - In windowed mode a clear without a prior arming read is a violation.
// - Any write to either control register clears the watchdog counters.
// - A clear in the closed window resets the chip and clears the flag.
// - A timeout during sleep wakes the device instead of resetting it.
`timescale 1ns/100ps
module wwc_top #(
   parameter int LF_DIV = wwc_pkg::LF_DIV,
   parameter int MF_DIV = wwc_pkg::MF_DIV
) (
   input wire logic I_MCLK,
   input wire logic I_NRST,
   input wire logic [wwc_pkg::AW-1:0] I_AVS_ADDRESS,
   input wire logic I_AVS_READ,
   input wire logic I_AVS_WRITE,
   input wire logic [3:0] I_AVS_BYTEENABLE,
   input wire logic [31:0] I_AVS_WRITEDATA,
   output logic [31:0] O_AVS_READDATA,
   output logic O_AVS_WAITREQUEST,
   input wire logic [4:0] I_CFG_TIMEOUT_SCALE,
   input wire logic [2:0] I_CFG_TICK_SOURCE,
   input wire logic [2:0] I_CFG_WINDOW_SIZE,
   input wire logic [1:0] I_WATCHDOG_MODE_CFG,
   input wire logic I_CLEAR_WATCHDOG_INSTR,
   input wire logic I_SLEEP,
   output logic O_WDT_RESET,
   output logic O_WAKE,
   output logic O_WINDOW_VIOLATION_FLAG_N,
   output logic O_IRQ
);
   wwc_pkg::wwc_regs_t q;
   wwc_pkg::wwc_regs_t d;
   wwc_pkg::wwc_avs_t avs;
   logic tick;
   logic en;
   logic req;
   logic take_rd;
   logic take_wr;
   logic lo_we;
   logic [wwc_pkg::CNT_W-1:0] lim;
   logic [wwc_pkg::CNT_W-1:0] dly;
   logic windowed;
   logic is_open;
   logic [31:0] rdv;
   logic [wwc_pkg::EV_W-1:0] ev;
   logic [wwc_pkg::EV_W-1:0] w1c;
   logic cfg_scale_open;
   logic cfg_src_open;
   logic cfg_win_open;
   logic [4:0] scale_rst;

   assign avs = '{read: I_AVS_READ, write: I_AVS_WRITE, addr: I_AVS_ADDRESS,
                  be: I_AVS_BYTEENABLE, wdata: I_AVS_WRITEDATA};

   // Every access waits one cycle, so read data come from a register.
   assign req = avs.read | avs.write;
   assign take_rd = avs.read & q.ack;
   assign take_wr = avs.write & q.ack;
   assign lo_we = take_wr & avs.be[0];
   assign O_AVS_WAITREQUEST = req & ~q.ack;

   assign cfg_scale_open = (I_CFG_TIMEOUT_SCALE == wwc_pkg::SCALE_OPEN);
   assign cfg_src_open = (I_CFG_TICK_SOURCE == wwc_pkg::SRC_OPEN);
   assign cfg_win_open = (I_CFG_WINDOW_SIZE == wwc_pkg::WIN_OPEN);
   assign scale_rst = cfg_scale_open ? wwc_pkg::SCALE_RST : I_CFG_TIMEOUT_SCALE;

   assign lim = wwc_pkg::wwc_lim(q.scale);
   assign dly = wwc_pkg::wwc_delay(q.scale, q.win);
   assign windowed = (q.win != wwc_pkg::WIN_OPEN);
   assign is_open = (q.cnt >= dly);

   wwc_tick_gen #(
      .LF_DIV(LF_DIV),
      .MF_DIV(MF_DIV)
   ) u_tick (
      .i_clk(I_MCLK),
      .i_nrst(I_NRST),
      .i_sel_mf(q.src == wwc_pkg::SRC_MF),
      .o_tick(tick)
   );

   // Operating mode decode; the software bit matters in one mode only.
   always_comb begin
      case (I_WATCHDOG_MODE_CFG)
         wwc_pkg::MODE_ON: en = 1'b1;
         wwc_pkg::MODE_NOSLP: en = ~I_SLEEP;
         wwc_pkg::MODE_SW: en = q.sw_on;
         default: en = 1'b0;
      endcase
   end

   // Read mux; undriven bits read as zero and unmapped addresses read zero.
   always_comb begin
      rdv = '0;
      case (avs.addr)
         wwc_pkg::A_CTRL0: begin
            rdv[wwc_pkg::C0_SW_BIT] = q.sw_on;
            rdv[wwc_pkg::C0_SCALE_LSB +: 5] = q.scale;
         end
         wwc_pkg::A_CTRL1: begin
            rdv[wwc_pkg::C1_WIN_LSB +: 3] = q.win;
            rdv[wwc_pkg::C1_SRC_LSB +: 3] = q.src;
         end
         wwc_pkg::A_PSL: rdv[7:0] = q.cnt[7:0];
         wwc_pkg::A_PSH: rdv[7:0] = q.cnt[15:8];
         wwc_pkg::A_TMR: begin
            rdv[wwc_pkg::TMR_PS_LSB +: 2] = q.cnt[17:16];
            rdv[wwc_pkg::TMR_STATE_BIT] = q.armed;
            rdv[wwc_pkg::TMR_CNT_LSB +: wwc_pkg::TMR_VIS_W] =
               q.cnt[wwc_pkg::PS_W +: wwc_pkg::TMR_VIS_W];
         end
         wwc_pkg::A_ISTAT: rdv[wwc_pkg::EV_W-1:0] = q.ist;
         wwc_pkg::A_IMASK: rdv[wwc_pkg::EV_W-1:0] = q.imask;
         wwc_pkg::A_FLAG: rdv[wwc_pkg::FLAG_BIT] = q.wv_n;
         default: rdv = '0;
      endcase
   end

   always_comb begin
      d = q;
      d.rst = 1'b0;
      d.wake = 1'b0;
      d.slp = I_SLEEP;
      d.ack = req & ~q.ack;
      ev = '0;
      w1c = '0;
      if (avs.read & ~q.ack) begin
         d.rdata = rdv;
      end

      case (q.st)
         wwc_pkg::ST_INIT: begin
            // Configuration fields are caught on the first edge after reset.
            d.scale = scale_rst;
            d.src = cfg_src_open ? wwc_pkg::SRC_RST : I_CFG_TICK_SOURCE;
            d.win = I_CFG_WINDOW_SIZE;
            d.st = wwc_pkg::ST_OFF;
         end
         wwc_pkg::ST_OFF: begin
            if (en) begin
               d.st = wwc_pkg::ST_RUN;
            end
         end
         wwc_pkg::ST_RUN: begin
            if (!en) begin
               d.st = wwc_pkg::ST_OFF;
            end
         end
         default: d.st = wwc_pkg::ST_INIT;
      endcase

      if (q.st == wwc_pkg::ST_RUN) begin
         if (tick) begin
            if (q.cnt == lim) begin
               d.cnt = '0;
               if (q.slp) begin
                  d.wake = 1'b1;
                  ev[wwc_pkg::EV_WAKE] = 1'b1;
               end else begin
                  d.rst = 1'b1;
                  ev[wwc_pkg::EV_TO] = 1'b1;
               end
            end else begin
               d.cnt = q.cnt + wwc_pkg::CNT_W'(1);
            end
         end
         if (I_CLEAR_WATCHDOG_INSTR) begin
            if (!windowed || (q.armed && is_open)) begin
               d.cnt = '0;
            end else begin
               // Unarmed or early clear: resets like a timeout, and also drives the flag low and raises the violation event.
               d.cnt = '0;
               d.rst = 1'b1;
               d.wv_n = 1'b0;
               ev[wwc_pkg::EV_WV] = 1'b1;
            end
            d.armed = 1'b0;
         end
      end else begin
         d.cnt = '0;
         d.armed = 1'b0;
      end

      // Entering or leaving sleep restarts the count.
      if (q.slp != I_SLEEP) begin
         d.cnt = '0;
      end

      if (take_rd && avs.addr == wwc_pkg::A_CTRL0 && q.st == wwc_pkg::ST_RUN) begin
         d.armed = 1'b1;
      end

      if (take_wr && (avs.addr == wwc_pkg::A_CTRL0 || avs.addr == wwc_pkg::A_CTRL1)) begin
         d.cnt = '0;
         d.armed = 1'b0;
      end

      if (lo_we && q.st != wwc_pkg::ST_INIT) begin
         case (avs.addr)
            wwc_pkg::A_CTRL0: begin
               d.sw_on = avs.wdata[wwc_pkg::C0_SW_BIT];
               if (cfg_scale_open) begin
                  d.scale = avs.wdata[wwc_pkg::C0_SCALE_LSB +: 5];
               end
            end
            wwc_pkg::A_CTRL1: begin
               if (cfg_src_open) begin
                  d.src = avs.wdata[wwc_pkg::C1_SRC_LSB +: 3];
               end
               if (cfg_win_open) begin
                  d.win = avs.wdata[wwc_pkg::C1_WIN_LSB +: 3];
               end
            end
            wwc_pkg::A_ISTAT: w1c = avs.wdata[wwc_pkg::EV_W-1:0];
            wwc_pkg::A_IMASK: d.imask = avs.wdata[wwc_pkg::EV_W-1:0];
            wwc_pkg::A_FLAG: begin
               if (avs.wdata[wwc_pkg::FLAG_BIT] && !ev[wwc_pkg::EV_WV]) begin
                  d.wv_n = 1'b1;
               end
            end
            default: d.imask = q.imask;
         endcase
      end

      // A new event in the clearing cycle keeps its bit set.
      d.ist = (q.ist & ~w1c) | ev;
   end

   always_ff @(posedge I_MCLK or negedge I_NRST) begin
      if (!I_NRST) begin
         q <= '0;
         q.st <= wwc_pkg::ST_INIT;
         q.wv_n <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign O_AVS_READDATA = q.rdata;
   assign O_WDT_RESET = q.rst;
   assign O_WAKE = q.wake;
   assign O_WINDOW_VIOLATION_FLAG_N = q.wv_n;
   assign O_IRQ = |(q.ist & q.imask);

   default clocking cb @(posedge I_MCLK);
   endclocking
   default disable iff (!I_NRST);

   property p_period_end;
      (q.st == wwc_pkg::ST_RUN && tick && q.cnt == lim && !I_CLEAR_WATCHDOG_INSTR && !avs.write
       && q.slp == I_SLEEP) |=> (q.cnt == '0) && (q.rst || q.wake);
   endproperty
   a_period_end: assert property (p_period_end) else $error("period end missed");

   property p_reserved_min;
      (q.scale > wwc_pkg::SCALE_MAX) |-> (lim == wwc_pkg::CNT_W'(31));
   endproperty
   a_reserved_min: assert property (p_reserved_min) else $error("reserved scale wrong");

   property p_scale_reset;
      (q.st == wwc_pkg::ST_INIT && I_NRST)
         |=> (q.scale == $past(scale_rst)) && (q.win == $past(I_CFG_WINDOW_SIZE));
   endproperty
   a_scale_reset: assert property (p_scale_reset) else $error("reset load wrong");

   property p_scale_ro;
      (take_wr && avs.addr == wwc_pkg::A_CTRL0 && !cfg_scale_open) |=> $stable(q.scale);
   endproperty
   a_scale_ro: assert property (p_scale_ro) else $error("scale written while locked");

   property p_off_cleared;
      (!en && q.st != wwc_pkg::ST_INIT) ##1 (!en) |=> (q.cnt == '0) && !q.rst;
   endproperty
   a_off_cleared: assert property (p_off_cleared) else $error("disabled watchdog ran");

   property p_src_ro;
      (take_wr && avs.addr == wwc_pkg::A_CTRL1 && !cfg_src_open) |=> $stable(q.src);
   endproperty
   a_src_ro: assert property (p_src_ro) else $error("source written while locked");

   property p_arm_read;
      (take_rd && avs.addr == wwc_pkg::A_CTRL0 && q.st == wwc_pkg::ST_RUN && !avs.write)
         |=> q.armed && (O_AVS_READDATA[7:6] == 2'h0);
   endproperty
   a_arm_read: assert property (p_arm_read) else $error("read did not arm");

   property p_violation;
      (q.st == wwc_pkg::ST_RUN && I_CLEAR_WATCHDOG_INSTR && windowed && !(q.armed && is_open))
         |=> O_WDT_RESET && !O_WINDOW_VIOLATION_FLAG_N && q.ist[wwc_pkg::EV_WV];
   endproperty
   a_violation: assert property (p_violation) else $error("violation not raised");

   property p_write_clears;
      (take_wr && (avs.addr == wwc_pkg::A_CTRL0 || avs.addr == wwc_pkg::A_CTRL1))
         |=> (q.cnt == '0) && !q.armed;
   endproperty
   a_write_clears: assert property (p_write_clears) else $error("write left count");

   property p_sleep_wake;
      (q.st == wwc_pkg::ST_RUN && tick && q.cnt == lim && q.slp && I_SLEEP)
         |=> O_WAKE && !O_WDT_RESET ##1 !O_WAKE;
   endproperty
   a_sleep_wake: assert property (p_sleep_wake) else $error("sleep timeout reset");

   property p_rd_zero;
      (avs.read && !q.ack && avs.addr == wwc_pkg::A_TMR) |=> (O_AVS_READDATA[31:7] == '0);
   endproperty
   a_rd_zero: assert property (p_rd_zero) else $error("unused bits not zero");

   property p_state_bit;
      (avs.read && !q.ack && avs.addr == wwc_pkg::A_TMR)
         |=> (O_AVS_READDATA[wwc_pkg::TMR_STATE_BIT] == $past(q.armed));
   endproperty
   a_state_bit: assert property (p_state_bit) else $error("armed bit wrong");

   property p_win_ro;
      (take_wr && avs.addr == wwc_pkg::A_CTRL1 && !cfg_win_open) |=> $stable(q.win);
   endproperty
   a_win_ro: assert property (p_win_ro) else $error("window written while locked");

   // A timeout in the same cycle still resets, so that corner is left out.
   property p_open_clear;
      (q.st == wwc_pkg::ST_RUN && I_CLEAR_WATCHDOG_INSTR && q.armed && is_open
       && !(tick && q.cnt == lim)) |=> !O_WDT_RESET && (q.cnt == '0);
   endproperty
   a_open_clear: assert property (p_open_clear) else $error("open clear refused");

   property p_ps_read;
      (avs.read && !q.ack && avs.addr == wwc_pkg::A_PSL)
         |=> (O_AVS_READDATA == {24'h000000, $past(q.cnt[7:0])});
   endproperty
   a_ps_read: assert property (p_ps_read) else $error("prescale low wrong");
endmodule

// *** sim/wwc_cpu_model.sv ***
// Behavioural CPU core that issues clear-watchdog instructions on request.
`timescale 1ns/100ps
module wwc_cpu_model (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_go,
   input wire logic [7:0] i_wait,
   output logic o_clear
);
   logic [8:0] cnt_q;

   // The clear is a single-cycle pulse, issued i_wait+1 cycles after the edge that samples the request.
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt_q <= 9'h000;
         o_clear <= 1'b0;
      end else begin
         o_clear <= (cnt_q == 9'h001);
         if (i_go) begin
            cnt_q <= {1'b0, i_wait} + 9'h001;
         end else if (cnt_q != 9'h000) begin
            cnt_q <= cnt_q - 9'h001;
         end
      end
   end
endmodule

// *** sim/tb_top.sv ***
// Self-checking bench of the windowed watchdog control block.
`timescale 1ns/100ps
module tb_top;
   localparam int LFD = 4;
   localparam int MFD = 3;
   logic mclk, nrst, rd, wr, go, slp, clr, wrst, wake, flg_n, irq, wreq;
   logic [4:0] addr, cs;
   logic [2:0] csrc, cwin;
   logic [1:0] mode, ev;
   logic [7:0] gw, q;
   logic [31:0] wdat, rdat;
   int num_errors, cmp_count, n, lo, hi;
   logic [4:0] tcode [5] = '{5'h00, 5'h01, 5'h02, 5'h13, 5'h1F};
   int tick [5] = '{32, 64, 128, 32, 32};
   int dv [5] = '{LFD, LFD, LFD, LFD, MFD};

   wwc_top #(.LF_DIV(LFD), .MF_DIV(MFD)) dut_u (.I_MCLK(mclk), .I_NRST(nrst),
      .I_AVS_ADDRESS(addr), .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_BYTEENABLE(4'hF),
      .I_AVS_WRITEDATA(wdat), .O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(wreq),
      .I_CFG_TIMEOUT_SCALE(cs), .I_CFG_TICK_SOURCE(csrc), .I_CFG_WINDOW_SIZE(cwin),
      .I_WATCHDOG_MODE_CFG(mode), .I_CLEAR_WATCHDOG_INSTR(clr), .I_SLEEP(slp),
      .O_WDT_RESET(wrst), .O_WAKE(wake), .O_WINDOW_VIOLATION_FLAG_N(flg_n), .O_IRQ(irq));

   wwc_cpu_model cpu_u (.i_clk(mclk), .i_nrst(nrst), .i_go(go), .i_wait(gw), .o_clear(clr));

   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   task automatic finish_test;
      $display("mismatches %0d comparisons %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // One Avalon-MM transfer, held until waitrequest is sampled low.
   task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
      @(posedge mclk);
      rd <= ~w;
      wr <= w;
      addr <= a;
      wdat <= {24'h000000, d};
      do begin
         @(posedge mclk);
      end while (wreq !== 1'b0);
      q = rdat[7:0];
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   task automatic rdc(input string nm, input logic [4:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk(nm, {24'h000000, q}, {24'h000000, e});
   endtask

   task automatic do_reset(input logic [4:0] s, input logic [2:0] c, input logic [2:0] w,
                           input logic [1:0] m);
      @(posedge mclk);
      nrst <= 1'b0;
      cs <= s;
      csrc <= c;
      cwin <= w;
      mode <= m;
      repeat (6) @(posedge mclk);
      nrst <= 1'b1;
      repeat (2) @(posedge mclk);
   endtask

   // Waits for a reset or wake pulse; ev holds {wake, reset} as seen.
   task automatic wait_evt(input int lim);
      n = 0;
      ev = 2'b00;
      while (n < lim && ev == 2'b00) begin
         @(posedge mclk);
         #1;
         n++;
         ev = {wake === 1'b1, wrst === 1'b1};
      end
   endtask

   task automatic clr_after(input logic [7:0] w);
      @(posedge mclk);
      go <= 1'b1;
      gw <= w;
      @(posedge mclk);
      go <= 1'b0;
   endtask

   initial begin
      num_errors = 0;
      cmp_count = 0;
      nrst = 1'b0;
      rd = 1'b0;
      wr = 1'b0;
      addr = 5'h00;
      wdat = 32'h00000000;
      go = 1'b0;
      gw = 8'h00;
      slp = 1'b0;
      cs = 5'h1F;
      csrc = 3'h7;
      cwin = 3'h7;
      mode = 2'h1;
      do_reset(5'h1F, 3'h7, 3'h7, 2'h1);
      rdc("ctrl0 reset", wwc_pkg::A_CTRL0, 8'h16);
      rdc("ctrl1 reset", wwc_pkg::A_CTRL1, 8'h07);
      rdc("psl reset", wwc_pkg::A_PSL, 8'h00);
      rdc("psh reset", wwc_pkg::A_PSH, 8'h00);
      rdc("tmr reset", wwc_pkg::A_TMR, 8'h00);
      rdc("unmapped", 5'h02, 8'h00);
      bus(1'b1, wwc_pkg::A_CTRL0, 8'hFF);
      rdc("ctrl0 open", wwc_pkg::A_CTRL0, 8'h3F);
      bus(1'b1, wwc_pkg::A_CTRL1, 8'hFF);
      rdc("ctrl1 open", wwc_pkg::A_CTRL1, 8'h77);
      for (int i = 0; i < 5; i++) begin
         bus(1'b1, wwc_pkg::A_CTRL1, (dv[i] == MFD) ? 8'h17 : 8'h07);
         bus(1'b1, wwc_pkg::A_CTRL0, {2'b00, tcode[i], 1'b1});
         wait_evt(800);
         // The first tick lands one to dv cycles after the clearing write.
         lo = (tick[i] - 1) * dv[i] + 1;
         hi = tick[i] * dv[i];
         chk("period", (ev == 2'b01 && n >= lo && n <= hi), 1);
      end
      bus(1'b1, wwc_pkg::A_CTRL1, 8'h03);
      bus(1'b1, wwc_pkg::A_CTRL0, 8'h01);
      repeat (60) @(posedge mclk);
      bus(1'b0, wwc_pkg::A_PSL, 8'h00);
      chk("psl running", (q >= 8'h08), 1);
      bus(1'b1, wwc_pkg::A_CTRL1, 8'h03);
      bus(1'b0, wwc_pkg::A_PSL, 8'h00);
      chk("psl cleared", (q <= 8'h02), 1);
      clr_after(8'h00);
      wait_evt(10);
      chk("unarmed clear", ev, 2'b01);
      chk("flag pin", flg_n, 1'b0);
      rdc("flag", wwc_pkg::A_FLAG, 8'h00);
      rdc("istat", wwc_pkg::A_ISTAT, 8'h03);
      #1 chk("irq masked", irq, 1'b0);
      bus(1'b1, wwc_pkg::A_IMASK, 8'h02);
      #1 chk("irq on", irq, 1'b1);
      bus(1'b1, wwc_pkg::A_ISTAT, 8'h02);
      #1 chk("irq off", irq, 1'b0);
      rdc("istat w1c", wwc_pkg::A_ISTAT, 8'h01);
      bus(1'b1, wwc_pkg::A_FLAG, 8'h01);
      rdc("flag set", wwc_pkg::A_FLAG, 8'h01);
      chk("flag pin set", flg_n, 1'b1);
      bus(1'b1, wwc_pkg::A_CTRL0, 8'h01);
      repeat (80) @(posedge mclk);
      bus(1'b0, wwc_pkg::A_CTRL0, 8'h00);
      rdc("armed", wwc_pkg::A_TMR, 8'h04);
      clr_after(8'h00);
      wait_evt(12);
      chk("open clear", ev, 2'b00);
      rdc("disarmed", wwc_pkg::A_TMR, 8'h00);
      bus(1'b1, wwc_pkg::A_CTRL0, 8'h01);
      bus(1'b0, wwc_pkg::A_CTRL0, 8'h00);
      clr_after(8'h00);
      wait_evt(12);
      chk("closed clear", ev, 2'b01);
      for (int m = 0; m < 4; m++) begin
         do_reset(5'h1F, 3'h7, 3'h7, 2'(m));
         bus(1'b1, wwc_pkg::A_CTRL0, (m == 0) ? 8'h01 : 8'h00);
         wait_evt(300);
         chk("mode", ev, (m >= 2) ? 2'b01 : 2'b00);
      end
      @(posedge mclk);
      slp <= 1'b1;
      bus(1'b1, wwc_pkg::A_CTRL0, 8'h00);
      wait_evt(300);
      chk("sleep timeout", ev, 2'b10);
      @(posedge mclk);
      slp <= 1'b0;
      do_reset(5'h05, 3'h1, 3'h3, 2'h0);
      rdc("ctrl0 cfg", wwc_pkg::A_CTRL0, 8'h0A);
      rdc("ctrl1 cfg", wwc_pkg::A_CTRL1, 8'h13);
      bus(1'b1, wwc_pkg::A_CTRL0, 8'hFE);
      bus(1'b1, wwc_pkg::A_CTRL1, 8'hFF);
      rdc("ctrl0 locked", wwc_pkg::A_CTRL0, 8'h0A);
      rdc("ctrl1 locked", wwc_pkg::A_CTRL1, 8'h13);
      finish_test();
   end

   initial begin
      #4000000;
      num_errors++;
      finish_test();
   end
endmodule
